/* File: src/fbe_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "fbe_defs.vh"
module fbe_top #(
  parameter [`FBE_CNT_W-1:0] SECT_ERASE_CYC = `FBE_SECT_MS * 1000 * `FBE_CLK_MHZ,
  parameter [`FBE_CNT_W-1:0] BANKA_ERASE_CYC = `FBE_BANKA_MS * 1000 * `FBE_CLK_MHZ,
  parameter [`FBE_CNT_W-1:0] BANKB_ERASE_CYC = `FBE_BANKB_MS * 1000 * `FBE_CLK_MHZ,
  parameter [`FBE_CNT_W-1:0] BANKE_ERASE_CYC = `FBE_BANKE_MS * 1000 * `FBE_CLK_MHZ
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire fetch_req_i,
  input wire [31:0] fetch_addr_i,
  output reg fetch_ready_o,
  output reg fetch_valid_o,
  output reg [`FBE_DATA_W-1:0] fetch_data_o,
  output reg [`FBE_ECC_W-1:0] fetch_ecc_o,
  output reg fetch_err_o,
  input wire ecc_event_i,
  output reg busy_o
);
  // the walk cycle counts toward the word's program time
  localparam [`FBE_CNT_W-1:0] PROG_CYC = `FBE_PROG_US * `FBE_CLK_MHZ - `FBE_PROG_WALK;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_WALK = 2'h1;
  localparam [1:0] S_WAIT = 2'h2;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // register file
  reg pipe_en_q;
  reg [31:0] paddr_q;
  reg [127:0] wdata_q;
  reg [15:0] wecc_q;
  reg [31:0] eaddr_q;
  reg cmderr_q;
  reg eccerr_q;
  reg [1:0] state_q;
  reg [1:0] op_q;
  reg [1:0] sbank_q;
  reg [3:0] ssect_q;
  reg [`FBE_IDX_W-1:0] sidx_q;
  reg [`FBE_CNT_W-1:0] cnt_q;

  wire bus_req = avs_read_i | avs_write_i;
  wire bus_go = bus_req & ~avs_waitrequest_o;
  wire wr_go = bus_go & avs_write_i;

  wire p_hit;
  wire [1:0] p_bank;
  wire [3:0] p_sect;
  wire [`FBE_IDX_W-1:0] p_idx;
  fbe_map u_pmap (
    .addr_i(paddr_q),
    .hit_o(p_hit),
    .bank_o(p_bank),
    .sector_o(p_sect),
    .idx_o(p_idx)
  );

  wire f_hit;
  wire [1:0] f_bank;
  wire [3:0] f_sect;
  wire [`FBE_IDX_W-1:0] f_idx;
  fbe_map u_fmap (
    .addr_i(fetch_addr_i),
    .hit_o(f_hit),
    .bank_o(f_bank),
    .sector_o(f_sect),
    .idx_o(f_idx)
  );

  wire [1:0] cmd_op = avs_writedata_i[1:0];
  wire cmd_wr = wr_go && avs_address_i == `FBE_REG_CMD && avs_byteenable_i[0];
  // a command while busy is dropped; one sequencer serves all banks
  wire cmd_go = cmd_wr && state_q == S_IDLE && cmd_op != `FBE_OP_NONE && p_hit;
  wire cmd_bad = cmd_wr && state_q == S_IDLE && cmd_op != `FBE_OP_NONE && !p_hit;

  // sequencer: walk the words, then hold busy for the array time
  wire walk_last = (op_q == `FBE_OP_PROG) ||
                   (op_q == `FBE_OP_SERASE && sidx_q[3:0] == 4'hf) ||
                   (op_q == `FBE_OP_BERASE && sidx_q == {`FBE_IDX_W{1'b1}});
  reg [`FBE_CNT_W-1:0] wait_cyc;
  always @* begin
    case (op_q)
      `FBE_OP_PROG: wait_cyc = PROG_CYC;
      `FBE_OP_SERASE: wait_cyc = SECT_ERASE_CYC;
      default: begin
        if (sbank_q == `FBE_BANK_A)
          wait_cyc = BANKA_ERASE_CYC;
        else if (sbank_q == `FBE_BANK_B)
          wait_cyc = BANKB_ERASE_CYC;
        else
          wait_cyc = BANKE_ERASE_CYC;
      end
    endcase
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      op_q <= `FBE_OP_NONE;
      sbank_q <= `FBE_BANK_A;
      ssect_q <= 4'h0;
      sidx_q <= {`FBE_IDX_W{1'b0}};
      cnt_q <= {`FBE_CNT_W{1'b0}};
    end else begin
      case (state_q)
        S_IDLE: begin
          if (cmd_go) begin
            state_q <= S_WALK;
            op_q <= cmd_op;
            sbank_q <= p_bank;
            ssect_q <= p_sect;
            if (cmd_op == `FBE_OP_PROG)
              sidx_q <= p_idx;
            else if (cmd_op == `FBE_OP_SERASE)
              sidx_q <= {p_sect, 4'h0};
            else
              sidx_q <= {`FBE_IDX_W{1'b0}};
          end
        end
        S_WALK: begin
          sidx_q <= sidx_q + 1'b1;
          if (walk_last) begin
            state_q <= S_WAIT;
            cnt_q <= wait_cyc;
          end
        end
        S_WAIT: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q <= 1)
            state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  wire seq_busy = state_q != S_IDLE;
  wire [`FBE_WORD_W-1:0] prog_word = {wecc_q[15:8], wdata_q[127:64],
                                      wecc_q[7:0], wdata_q[63:0]};
  wire [`FBE_WORD_W-1:0] wr_word = (op_q == `FBE_OP_PROG) ? prog_word :
                                   {`FBE_WORD_W{1'b1}};

  // banks: each has its own port, so reads elsewhere go on during a job
  wire [`FBE_WORD_W-1:0] rd_word [0:`FBE_NBANK-1];
  genvar g;
  generate
    for (g = 0; g < `FBE_NBANK; g = g + 1) begin : g_bank
      fbe_mem #(
        .DW(`FBE_WORD_W),
        .AW(`FBE_IDX_W)
      ) u_mem (
        .mclk_i(mclk_i),
        .we_i(state_q == S_WALK && sbank_q == g),
        .waddr_i(sidx_q),
        .wdata_i(wr_word),
        .raddr_i(f_idx),
        .rdata_o(rd_word[g])
      );
    end
  endgenerate

  // fetch pipeline: stage one waits for array data, stage two drives out
  reg s1_valid_q;
  reg s1_err_q;
  reg [1:0] s1_bank_q;
  reg s1_half_q;
  reg [31:0] s1_addr_q;
  reg [31:0] last_addr_q;
  wire f_take = fetch_req_i & fetch_ready_o;
  wire f_bad = !f_hit || (seq_busy && f_bank == sbank_q);
  wire [`FBE_HALF_W-1:0] s1_half = s1_half_q ? rd_word[s1_bank_q][143:72] :
                                                rd_word[s1_bank_q][71:0];

  always @(posedge mclk_i) begin
    if (rst_i) begin
      s1_valid_q <= 1'b0;
      s1_err_q <= 1'b0;
      s1_bank_q <= `FBE_BANK_A;
      s1_half_q <= 1'b0;
      s1_addr_q <= 32'h0000_0000;
      last_addr_q <= 32'h0000_0000;
      fetch_ready_o <= 1'b0;
      fetch_valid_o <= 1'b0;
      fetch_data_o <= {`FBE_DATA_W{1'b0}};
      fetch_ecc_o <= {`FBE_ECC_W{1'b0}};
      fetch_err_o <= 1'b0;
    end else begin
      s1_valid_q <= f_take;
      if (f_take) begin
        s1_err_q <= f_bad;
        s1_bank_q <= f_bank;
        s1_half_q <= fetch_addr_i[3];
        s1_addr_q <= fetch_addr_i;
      end
      // without pipelining only one fetch is in flight
      fetch_ready_o <= pipe_en_q | ~(f_take | s1_valid_q);
      fetch_valid_o <= s1_valid_q;
      if (s1_valid_q) begin
        last_addr_q <= s1_addr_q;
        fetch_err_o <= s1_err_q;
        // error answers carry no array data
        fetch_data_o <= s1_err_q ? {`FBE_DATA_W{1'b0}} : s1_half[63:0];
        fetch_ecc_o <= s1_err_q ? {`FBE_ECC_W{1'b0}} : s1_half[71:64];
      end
    end
  end

  // register bus
  reg [31:0] rd_mux;
  always @* begin
    case (avs_address_i)
      `FBE_REG_CTRL: rd_mux = {31'h0, pipe_en_q};
      `FBE_REG_PADDR: rd_mux = paddr_q;
      `FBE_REG_STAT: rd_mux = {27'h0, eccerr_q, cmderr_q, sbank_q, seq_busy};
      `FBE_REG_WD0: rd_mux = wdata_q[31:0];
      `FBE_REG_WD1: rd_mux = wdata_q[63:32];
      `FBE_REG_WD2: rd_mux = wdata_q[95:64];
      `FBE_REG_WD3: rd_mux = wdata_q[127:96];
      `FBE_REG_WECC: rd_mux = {16'h0, wecc_q};
      `FBE_REG_EADDR: rd_mux = eaddr_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  wire st_wr = wr_go && avs_address_i == `FBE_REG_STAT && avs_byteenable_i[0];

  always @(posedge mclk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      pipe_en_q <= 1'b0;
      paddr_q <= 32'h0000_0000;
      wdata_q <= 128'h0;
      wecc_q <= 16'hffff;
      eaddr_q <= 32'h0000_0000;
      cmderr_q <= 1'b0;
      eccerr_q <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      // one wait cycle per access, then one answer cycle
      avs_waitrequest_o <= ~(avs_waitrequest_o & bus_req);
      if (avs_waitrequest_o & avs_read_i)
        avs_readdata_o <= rd_mux;
      busy_o <= seq_busy;
      if (wr_go) begin
        case (avs_address_i)
          `FBE_REG_CTRL:
            if (avs_byteenable_i[0])
              pipe_en_q <= avs_writedata_i[0];
          `FBE_REG_PADDR: paddr_q <= merge(paddr_q, avs_writedata_i, avs_byteenable_i);
          `FBE_REG_WD0:
            wdata_q[31:0] <= merge(wdata_q[31:0], avs_writedata_i, avs_byteenable_i);
          `FBE_REG_WD1:
            wdata_q[63:32] <= merge(wdata_q[63:32], avs_writedata_i, avs_byteenable_i);
          `FBE_REG_WD2:
            wdata_q[95:64] <= merge(wdata_q[95:64], avs_writedata_i, avs_byteenable_i);
          `FBE_REG_WD3:
            wdata_q[127:96] <= merge(wdata_q[127:96], avs_writedata_i, avs_byteenable_i);
          `FBE_REG_WECC: begin
            if (avs_byteenable_i[0])
              wecc_q[7:0] <= avs_writedata_i[7:0];
            if (avs_byteenable_i[1])
              wecc_q[15:8] <= avs_writedata_i[15:8];
          end
          default: ;
        endcase
      end
      // sticky flags: write one clears, a new event in the same cycle wins
      if (cmd_bad)
        cmderr_q <= 1'b1;
      else if (st_wr && avs_writedata_i[`FBE_ST_CMDERR])
        cmderr_q <= 1'b0;
      if (ecc_event_i) begin
        eccerr_q <= 1'b1;
        eaddr_q <= last_addr_q;
      end else if (st_wr && avs_writedata_i[`FBE_ST_ECCERR]) begin
        eccerr_q <= 1'b0;
      end
    end
  end
endmodule // fbe_top
`default_nettype wire

/* File: src/fbe_defs.vh */
`ifndef FBE_DEFS_VH
`define FBE_DEFS_VH
`define FBE_WORD_W 144
`define FBE_HALF_W 72
`define FBE_DATA_W 64
`define FBE_ECC_W 8
`define FBE_IDX_W 8
`define FBE_WPS 4
`define FBE_BANK_A 2'h0
`define FBE_BANK_B 2'h1
`define FBE_BANK_E 2'h2
`define FBE_NBANK 3
// address map
`define FBE_A_SMALL_LIM 4'h0
`define FBE_A_BIG_OFS 4'h3
`define FBE_B_FIRST 5'h0c
`define FBE_B_LAST 5'h17
`define FBE_E_BASE 16'hf020
// timing
`define FBE_CLK_MHZ 50
`define FBE_PROG_US 40
`define FBE_PROG_WALK 1
`define FBE_SECT_MS 30
`define FBE_BANKA_MS 300
`define FBE_BANKB_MS 240
`define FBE_BANKE_MS 80
`define FBE_CNT_W 24
// registers, byte offsets
`define FBE_REG_CTRL 6'h00
`define FBE_REG_CMD 6'h04
`define FBE_REG_PADDR 6'h08
`define FBE_REG_STAT 6'h0c
`define FBE_REG_WD0 6'h10
`define FBE_REG_WD1 6'h14
`define FBE_REG_WD2 6'h18
`define FBE_REG_WD3 6'h1c
`define FBE_REG_WECC 6'h20
`define FBE_REG_EADDR 6'h24
// commands
`define FBE_OP_NONE 2'h0
`define FBE_OP_PROG 2'h1
`define FBE_OP_SERASE 2'h2
`define FBE_OP_BERASE 2'h3
// status bits
`define FBE_ST_BUSY 0
`define FBE_ST_CMDERR 3
`define FBE_ST_ECCERR 4
`endif

/* File: src/fbe_mem.v */
`timescale 1ns/1ps
`default_nettype none
// one bank array, registered read port
module fbe_mem #(
  parameter DW = 144,
  parameter AW = 8
) (
  input wire mclk_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);
  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  always @(posedge mclk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule // fbe_mem
`default_nettype wire

/* File: src/fbe_map.v */
`timescale 1ns/1ps
`default_nettype none
`include "fbe_defs.vh"
// sector decoder; word index keeps 16 model words per sector
module fbe_map (
  input wire [31:0] addr_i,
  output reg hit_o,
  output reg [1:0] bank_o,
  output reg [3:0] sector_o,
  output wire [`FBE_IDX_W-1:0] idx_o
);
  wire [4:0] big = addr_i[21:17];
  wire [4:0] b_sect = big - `FBE_B_FIRST;

  assign idx_o = {sector_o, addr_i[7:4]};

  always @* begin
    hit_o = 1'b0;
    bank_o = `FBE_BANK_A;
    sector_o = 4'h0;
    if (addr_i[31:21] == 11'h000 && big < `FBE_B_FIRST) begin
      hit_o = 1'b1;
      if (addr_i[20:17] == `FBE_A_SMALL_LIM)
        sector_o = {2'h0, addr_i[16:15]};
      else
        sector_o = addr_i[20:17] + `FBE_A_BIG_OFS;
    end else if (addr_i[31:22] == 10'h000 && big <= `FBE_B_LAST) begin
      hit_o = 1'b1;
      bank_o = `FBE_BANK_B;
      sector_o = b_sect[3:0];
    end else if (addr_i[31:16] == `FBE_E_BASE) begin
      hit_o = 1'b1;
      bank_o = `FBE_BANK_E;
      sector_o = {2'h0, addr_i[15:14]};
    end
  end
endmodule // fbe_map
`default_nettype wire

/* File: tb/fbe_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module fbe_top_monitor (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic fetch_req_i,
  input wire logic [31:0] fetch_addr_i,
  input wire logic fetch_ready_o,
  input wire logic fetch_valid_o,
  input wire logic [63:0] fetch_data_o,
  input wire logic [7:0] fetch_ecc_o,
  input wire logic fetch_err_o,
  input wire logic busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire take = fetch_req_i && fetch_ready_o;
  wire mapped = fetch_addr_i < 32'h0030_0000 || fetch_addr_i[31:16] == 16'hf020;
  a_bus_answer: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
    else $error("bus answer not one cycle after request");
  a_bus_release: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("bus answer held too long");
  a_answer_lat: assert property (take |-> ##2 fetch_valid_o)
    else $error("fetch answer late");
  a_answer_cause: assert property (fetch_valid_o |-> $past(take, 2))
    else $error("fetch answer without request");
  a_err_blank: assert property (fetch_valid_o && fetch_err_o |-> fetch_data_o == 64'h0 && fetch_ecc_o == 8'h0)
    else $error("error answer carries data");
  a_unmapped_err: assert property (take && !mapped |-> ##2 fetch_valid_o && fetch_err_o)
    else $error("unmapped fetch not refused");
  a_free_bank: assert property (take && mapped && !busy_o ##1 !busy_o |-> ##1 !fetch_err_o)
    else $error("mapped fetch refused while idle");
  a_busy_span: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("sequencer job too short");
  c_take: cover property (take && mapped);
  c_err: cover property (fetch_valid_o && fetch_err_o);
  c_busy: cover property ($rose(busy_o));
endmodule // fbe_top_monitor
bind fbe_top fbe_top_monitor u_mon (.mclk_i, .rst_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .fetch_req_i, .fetch_addr_i, .fetch_ready_o, .fetch_valid_o,
  .fetch_data_o, .fetch_ecc_o, .fetch_err_o, .busy_o);
`default_nettype wire

/* File: tb/fbe_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fbe_host_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic chk_en_i,
  input wire logic [31:0] addr_i,
  input wire logic fetch_valid_i,
  input wire logic fetch_err_i,
  input wire logic [63:0] fetch_data_i,
  input wire logic [7:0] fetch_ecc_i,
  output wire logic fetch_req_o,
  output wire logic [31:0] fetch_addr_o,
  output var logic ecc_event_o
);
  wire [63:0] d = fetch_data_i;
  // stand-in check code, byte parity of the data word
  wire [7:0] calc = d[63:56] ^ d[55:48] ^ d[47:40] ^ d[39:32] ^ d[31:24] ^ d[23:16] ^ d[15:8] ^ d[7:0];
  assign fetch_req_o = go_i; // data reads only, never code
  // released address lines must not look valid
  assign fetch_addr_o = go_i ? addr_i : ~addr_i;
  always @(posedge mclk_i) begin
    if (rst_i) begin
      ecc_event_o <= 1'b0;
    end else begin
      ecc_event_o <= chk_en_i && fetch_valid_i && !fetch_err_i && calc != fetch_ecc_i;
    end
  end
endmodule // fbe_host_model
`default_nettype wire

/* File: tb/fbe_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fbe_top_tb;
  logic mclk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0, go = 1'b0, en = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic [31:0] avs_writedata_i = 32'h0, fa = 32'h0, rd, avs_readdata_o, fetch_addr_i;
  logic avs_waitrequest_o, fetch_req_i, fetch_ready_o, fetch_valid_o, fetch_err_o, ecc_event_i, busy_o, fr;
  logic [63:0] fetch_data_o, fd;
  logic [7:0] fetch_ecc_o, fe;
  int fail_count = 0, num_checks = 0, vcnt = 0, bcnt = 0, c0;
  logic [31:0] amap [11] = '{32'h0, 32'h7ff8, 32'h2_0000, 32'h17_fff8, 32'h18_0000, 32'h2f_fff8,
    32'hf020_0000, 32'hf020_fff8, 32'h30_0000, 32'hf01f_fff8, 32'hf021_0000};
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (fetch_valid_o === 1'b1) vcnt <= vcnt + 1;
  always @(posedge mclk_i) if (busy_o === 1'b1) bcnt <= bcnt + 1;
  // short erase counts keep the run brief
  fbe_top #(.SECT_ERASE_CYC(24'd20), .BANKA_ERASE_CYC(24'd20), .BANKB_ERASE_CYC(24'd20),
    .BANKE_ERASE_CYC(24'd20)) u_dut (.mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o, .fetch_req_i,
    .fetch_addr_i, .fetch_ready_o, .fetch_valid_o, .fetch_data_o, .fetch_ecc_o, .fetch_err_o,
    .ecc_event_i, .busy_o);
  fbe_host_model u_host (.mclk_i, .rst_i, .go_i(go), .chk_en_i(en), .addr_i(fa),
    .fetch_valid_i(fetch_valid_o), .fetch_err_i(fetch_err_o), .fetch_data_i(fetch_data_o),
    .fetch_ecc_i(fetch_ecc_o), .fetch_req_o(fetch_req_i), .fetch_addr_o(fetch_addr_i),
    .ecc_event_o(ecc_event_i));
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    n = 0;
    do begin @(posedge mclk_i); n++; end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (avs_waitrequest_o !== 1'b0) fail_count++;
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task rdchk(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task fetch(input logic [31:0] a);
    int n;
    @(posedge mclk_i);
    go <= 1'b1;
    fa <= a;
    n = 0;
    do begin @(posedge mclk_i); n++; end while (fetch_ready_o !== 1'b1 && n < 50);
    if (fetch_ready_o !== 1'b1) fail_count++;
    go <= 1'b0;
    n = 0;
    do begin @(posedge mclk_i); n++; end while (fetch_valid_o !== 1'b1 && n < 50);
    if (fetch_valid_o !== 1'b1) fail_count++;
    fd = fetch_data_o;
    fe = fetch_ecc_o;
    fr = fetch_err_o;
  endtask
  task job(input logic [31:0] pa, input logic [1:0] op);
    bus(1'b1, 6'h08, pa);
    bus(1'b1, 6'h04, {30'h0, op});
  endtask
  task idle;
    int n;
    repeat (2) @(posedge mclk_i);
    n = 0;
    while (busy_o !== 1'b0 && n < 5000) begin @(posedge mclk_i); n++; end
    if (busy_o !== 1'b0) fail_count++;
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdchk("stat", 6'h0c, 32'h0);
    rdchk("wecc", 6'h20, 32'hffff);
    rdchk("ctrl", 6'h00, 32'h0);
    rdchk("hole", 6'h3c, 32'h0);
    for (int i = 0; i < 11; i++) begin
      fetch(amap[i]);
      chk("map err", fr, i > 7);
    end
    for (int i = 0; i < 4; i++) bus(1'b1, 6'h10 + 6'(4 * i), 32'h0a0b_0c00 | i);
    bus(1'b1, 6'h20, 32'h5aa5);
    c0 = bcnt;
    job(32'h0, 2'h1);
    fetch(32'h0);
    chk("busy bank", fr, 1);
    fetch(32'hf020_0000);
    chk("free bank", fr, 0);
    idle;
    // 40 us at 50 MHz, overhead included
    chk("prog time", bcnt - c0, 2000);
    fetch(32'h0);
    chk("half0", fd, 64'h0a0b0c01_0a0b0c00);
    chk("ecc0", fe, 8'ha5);
    fetch(32'h8);
    chk("half1", fd, 64'h0a0b0c03_0a0b0c02);
    chk("ecc1", fe, 8'h5a);
    rdchk("stat a", 6'h0c, 32'h0);
    job(32'hf020_0010, 2'h1);
    fetch(32'h0018_0000);
    chk("fetch b", fr, 0);
    idle;
    rdchk("stat e", 6'h0c, 32'h4);
    fetch(32'hf020_0010);
    chk("eeprom", fd, 64'h0a0b0c01_0a0b0c00);
    job(32'h40, 2'h2);
    idle;
    fetch(32'h8);
    chk("sector", fd, 64'hffff_ffff_ffff_ffff);
    chk("sector ecc", fe, 8'hff);
    job(32'h002f_fff0, 2'h3);
    fetch(32'hf020_0010);
    chk("other bank", fr, 0);
    idle;
    fetch(32'h0018_0000);
    chk("bank", fd, 64'hffff_ffff_ffff_ffff);
    rdchk("stat b", 6'h0c, 32'h2);
    job(32'h0030_0000, 2'h1);
    bus(1'b0, 6'h0c, 32'h0);
    chk("cmd err", rd & 32'h19, 32'h8);
    bus(1'b1, 6'h0c, 32'h8);
    bus(1'b0, 6'h0c, 32'h0);
    chk("cmd clear", rd & 32'h19, 32'h0);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, 6'h00, p);
      c0 = vcnt;
      @(posedge mclk_i);
      go <= 1'b1;
      fa <= 32'h0;
      repeat (8) @(posedge mclk_i);
      go <= 1'b0;
      repeat (4) @(posedge mclk_i);
      chk("rate", vcnt - c0, p ? 8 : 3);
    end
    fetch(32'h7ff0);
    bus(1'b0, 6'h0c, 32'h0);
    chk("quiet", rd[4], 0);
    en <= 1'b1;
    fetch(32'h7ff0);
    repeat (2) @(posedge mclk_i);
    rdchk("err addr", 6'h24, 32'h7ff0);
    bus(1'b0, 6'h0c, 32'h0);
    chk("err flag", rd[4], 1);
    finish_test;
  end
  // whole run needs well under a quarter of this
  initial begin
    #1_000_000;
    fail_count++;
    finish_test;
  end
endmodule // fbe_top_tb
`default_nettype wire
